// file: dv/ocd_load.sv
// clock load model: run-length meter on one channel's first output pair
`timescale 1ns/10ps
module ocd_load
(
   input wire logic clk,
   input wire logic [2:0] p,
   output int low_len,
   output int high_len
);
   int run = 0;
   logic last = 1'bx;
   // measure each settled level run, in input cycles
   always @(posedge clk) begin
      if (p[0] === last) begin
         run++;
      end else begin
         if (last === 1'b0) low_len = run;
         if (last === 1'b1) high_len = run;
         run = 1;
         last = p[0];
      end
   end
endmodule

// file: dv/output_channel_divider_control_tb.sv
// self-checking bench for the channel 2/3 divider block
`timescale 1ns/10ps
module output_channel_divider_control_tb;
   logic clk, rst_n, cyc, stb, we, sync_n, ack;
   logic [11:0] adr;
   logic [3:0] sel;
   logic [31:0] dat_i, dat_o;
   logic [2:0] c2p, c2n, c2oe_n, c3p, c3n, c3oe_n;
   logic [1:0] dcc;
   int low2, high2, low3, high3, num_errors, compares, cycles, n0, n1;
   int model[int];
   logic [7:0] q, v;

   ocd_top dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .sync_n(sync_n),
      .channel2_first_output_pair_p(c2p), .channel2_first_output_pair_n(c2n),
      .channel2_first_output_pair_oe_n(c2oe_n),
      .channel3_first_output_pair_p(c3p), .channel3_first_output_pair_n(c3n),
      .channel3_first_output_pair_oe_n(c3oe_n), .duty_cycle_correction(dcc));
   ocd_load load2 (.clk(clk), .p(c2p), .low_len(low2), .high_len(high2));
   ocd_load load3 (.clk(clk), .p(c3p), .low_len(low3), .high_len(high3));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic results();
      if (num_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         results();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one classic wishbone cycle; model updated at the acked edge
   task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d,
                     input logic [3:0] s, output logic [7:0] r);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= s;
      dat_i <= {24'h000000, d};
      do @(posedge clk); while (ack !== 1'b1);
      r = dat_o[7:0];
      if (w && s[0] && idx >= 10'h196 && idx <= 10'h19b) begin
         model[idx] = (idx == 10'h198 || idx == 10'h19b) ? (d & 8'h05) : d;
      end
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      wb(1'b1, idx, d, 4'hf, q);
   endtask

   task automatic rd_check(input logic [9:0] idx);
      wb(1'b0, idx, 8'h00, 4'hf, q);
      check("register", {14'h0, idx, q},
            {14'h0, idx, model.exists(idx) ? model[idx][7:0] : 8'h00});
   endtask

   // cycles from sync release until channel 2 first goes high
   task automatic run_after_sync(input logic [3:0] ph, output int n);
      wr(10'h197, {4'h0, ph});
      sync_n <= 1'b0;
      repeat (10) @(posedge clk);
      check("held low", c2p, 3'b000);
      sync_n <= 1'b1;
      n = 0;
      while (c2p[0] !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
   endtask

   initial begin
      {cyc, stb, we, adr, sel, dat_i} = '0;
      sync_n = 1'b1;
      rst_n = 1'b0;
      void'($urandom(49));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      model[10'h196] = 8'h11;
      for (int i = 10'h197; i <= 10'h19b; i++) model[i] = 8'h00;
      for (int i = 10'h196; i <= 10'h19b; i++) rd_check(i[9:0]);
      check("dcc reset", dcc, 2'b11);
      repeat (40) @(posedge clk);
      @(negedge clk);
      check("div2 low", low2, 2);
      check("div2 high", high2, 2);
      check("inverse", c2n, 3'(~c2p));
      for (int i = 10'h196; i <= 10'h19c; i++) begin
         if (i != 10'h19c) wr(i[9:0], 8'($urandom));
         if (i != 10'h19c) rd_check(i[9:0]);
      end
      wr(10'h1ff, 8'h5a);
      rd_check(10'h1ff);
      wb(1'b1, 10'h199, 8'h77, 4'he, q);
      rd_check(10'h199);
      for (int i = 10'h196; i <= 10'h19b; i++) wr(i[9:0], 8'h00);
      for (int k = 0; k < 6; k++) begin
         v = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
         wr(10'h199, v);
         repeat (80) @(posedge clk);
         @(negedge clk);
         check("div3 low", low3, v[7:4] + 1);
         check("div3 high", high3, v[3:0] + 1);
      end
      run_after_sync(4'h0, n0);
      run_after_sync(4'h9, n1);
      check("phase 9", n1 - n0, 9);
      run_after_sync(4'hf, n1);
      check("phase 15", n1 - n0, 15);
      wr(10'h197, 8'h10);
      sync_n <= 1'b0;
      repeat (10) @(posedge clk);
      check("start high", c2p, 3'b111);
      wr(10'h197, 8'h20);
      repeat (6) @(posedge clk);
      check("obey sync", c2p, 3'b000);
      wr(10'h197, 8'h40);
      wr(10'h197, 8'h60);
      repeat (6) @(posedge clk);
      check("force high", c2p, 3'b111);
      wr(10'h197, 8'h40);
      repeat (6) @(posedge clk);
      check("force low", c2p, 3'b000);
      wb(1'b0, 10'h19c, 8'h00, 4'hf, q);
      check("status", q, 8'h04);
      wr(10'h197, 8'he0);
      repeat (4) @(posedge clk);
      #5;
      check("bypass high", c2p, 3'b111);
      #10;
      check("bypass low", c2p, 3'b000);
      @(posedge clk);
      sync_n <= 1'b1;
      wr(10'h198, 8'h05);
      repeat (2) @(posedge clk);
      check("ch2 oe", c2oe_n, 3'b111);
      check("ch2 pins", {c2p, c2n}, 6'h00);
      check("ch2 dcc", dcc, 2'b10);
      check("ch3 oe", c3oe_n, 3'b000);
      wr(10'h19b, 8'h04);
      wr(10'h198, 8'h00);
      repeat (2) @(posedge clk);
      check("ch3 oe", c3oe_n, 3'b111);
      check("ch2 back", c2oe_n, 3'b000);
      check("dcc", dcc, 2'b11);
      results();
   end
endmodule

// file: rtl/ocd_cfg.svh
// register indices, field positions, reset values for the channel divider block
`ifndef OCD_CFG_SVH
`define OCD_CFG_SVH

`define OCD_IDX_DIV2_COUNTS 10'h196
`define OCD_IDX_DIV2_CTRL 10'h197
`define OCD_IDX_CH2_PWR 10'h198
`define OCD_IDX_DIV3_COUNTS 10'h199
`define OCD_IDX_DIV3_CTRL 10'h19a
`define OCD_IDX_CH3_PWR 10'h19b
`define OCD_IDX_STATUS 10'h19c

`define OCD_LOW_MSB 7
`define OCD_LOW_LSB 4
`define OCD_HIGH_MSB 3
`define OCD_HIGH_LSB 0
`define OCD_BYPASS_BIT 7
`define OCD_IGNSYNC_BIT 6
`define OCD_FORCE_BIT 5
`define OCD_START_BIT 4
`define OCD_PHASE_MSB 3
`define OCD_PHASE_LSB 0
`define OCD_PD_BIT 2
`define OCD_DCCDIS_BIT 0
`define OCD_PWR_MASK 8'h05

`define OCD_RST_DIV2_COUNTS 8'h11
`define OCD_RST_DIV2_CTRL 8'h00
`define OCD_RST_CH2_PWR 8'h00
`define OCD_RST_DIV3_COUNTS 8'h00
`define OCD_RST_DIV3_CTRL 8'h00
`define OCD_RST_CH3_PWR 8'h00

`define OCD_ACK_LATENCY 1

`endif

// file: rtl/ocd_divider.sv
// one channel divider: low/high counts, phase offset, start level, force, bypass
`timescale 1ns/10ps
module ocd_divider
   import ocd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] low_cnt,
   input wire logic [3:0] high_cnt,
   input wire logic bypass,
   input wire logic ignore_sync,
   input wire logic force_high,
   input wire logic start_high,
   input wire logic [3:0] phase,
   input wire logic sync_hold,
   output logic level,
   output logic div_out
);

   ocd_state_t st;
   ocd_state_t next_st;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic next_level;

   function automatic logic [3:0] ocd_field(input logic lvl, input logic [3:0] lo,
                                            input logic [3:0] hi);
      ocd_field = lvl ? hi : lo;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st = st;
      next_cnt = cnt;
      next_level = level;
      if (bypass) begin
         next_st = OCD_ST_HOLD;
         next_cnt = 4'h0;
         next_level = start_high;
      end else if (sync_hold && ignore_sync) begin
         next_st = OCD_ST_FORCE;
         next_level = force_high;
      end else if (sync_hold) begin
         next_st = OCD_ST_HOLD;
         next_cnt = 4'h0;
         next_level = start_high;
      end else begin
         case (st)
            OCD_ST_HOLD: begin
               next_level = start_high;
               if (phase == 4'h0) begin
                  next_st = OCD_ST_RUN;
                  next_cnt = ocd_field(start_high, low_cnt, high_cnt);
               end else begin
                  next_st = OCD_ST_PHASE;
                  next_cnt = phase;
               end
            end
            OCD_ST_PHASE: begin
               if (cnt <= 4'h1) begin
                  next_st = OCD_ST_RUN;
                  next_cnt = ocd_field(level, low_cnt, high_cnt);
               end else begin
                  next_cnt = cnt - 4'h1;
               end
            end
            OCD_ST_RUN: begin
               if (cnt == 4'h0) begin
                  next_level = !level;
                  next_cnt = ocd_field(!level, low_cnt, high_cnt);
               end else begin
                  next_cnt = cnt - 4'h1;
               end
            end
            OCD_ST_FORCE: begin
               next_st = OCD_ST_HOLD;
            end
            default: begin
               next_st = OCD_ST_HOLD;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= OCD_ST_HOLD;
         cnt <= 4'h0;
         level <= 1'b0;
      end else begin
         st <= next_st;
         cnt <= next_cnt;
         level <= next_level;
      end
   end

   assign div_out = bypass ? clk : level;

   ////////////////////////////////////////////////////////////////////////
   sequence s_running;
      st == OCD_ST_RUN && !bypass && !sync_hold;
   endsequence

   sequence s_release;
      st == OCD_ST_HOLD && !bypass && !sync_hold;
   endsequence

   a_low_time: assert property (@(posedge clk) disable iff (!rst_n)
      (s_running and (!level && cnt == 4'h0)) |=> (level && cnt == $past(high_cnt)))
      else $error("low phase did not end into high count");

   a_high_time: assert property (@(posedge clk) disable iff (!rst_n)
      (s_running and (level && cnt == 4'h0)) |=> (!level && cnt == $past(low_cnt)))
      else $error("high phase did not end into low count");

   a_bypass_park: assert property (@(posedge clk) disable iff (!rst_n)
      bypass |=> (st == OCD_ST_HOLD && cnt == 4'h0))
      else $error("divider not parked under bypass");

   a_sync_restart: assert property (@(posedge clk) disable iff (!rst_n)
      (sync_hold && !ignore_sync && !bypass) |=> (st == OCD_ST_HOLD && level == $past(start_high)))
      else $error("obeyed sync did not restart divider");

   a_force_level: assert property (@(posedge clk) disable iff (!rst_n)
      (sync_hold && ignore_sync && !bypass) |=> (st == OCD_ST_FORCE && level == $past(force_high)))
      else $error("forced level wrong");

   a_phase_start: assert property (@(posedge clk) disable iff (!rst_n)
      (s_release and (phase != 4'h0)) |=> (st == OCD_ST_PHASE && cnt == $past(phase)))
      else $error("phase offset not loaded");

   a_start_level: assert property (@(posedge clk) disable iff (!rst_n)
      s_release |=> (level == $past(start_high)))
      else $error("start level wrong");

   a_run_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (s_running and (cnt != 4'h0)) |=> $stable(level) && cnt == $past(cnt) - 4'h1)
      else $error("level changed before count expired");

endmodule

// file: rtl/ocd_pkg.sv
// types shared by the channel divider block
package ocd_pkg;
   typedef enum logic [1:0] {
      OCD_ST_HOLD = 2'b00,
      OCD_ST_PHASE = 2'b01,
      OCD_ST_RUN = 2'b10,
      OCD_ST_FORCE = 2'b11
   } ocd_state_t;
endpackage

// file: rtl/ocd_top.sv
// channel 2 and 3 output dividers with classic wishbone register slave
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/10ps
`include "ocd_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Each divider holds its output low for the low-count field plus one input cycles.
// - Each divider holds its output high for the high-count field plus one input cycles.
// - The bypass bit parks the divider and passes the input clock straight to the output.
// - With ignore-sync clear the divider obeys the sync signal, with it set sync forces the output to the force-bit level.
// - While forcing is in effect the output sits at the level of the force bit.
// - The force bit has no effect on a bypassed divider.
// - The start-level bit picks whether the divided clock begins low or high.
// - Each divider delays its start by a four-bit phase offset, reset value zero.
// - The channel power-down bit puts all three output pairs in high impedance.
// - The channel two power-down bit acts on output pairs six to eight.
// - The channel three power-down bit acts on output pairs nine to eleven.
// - Duty-cycle correction is on while its disable bit is zero and off when it is one.
// - Divider two has its own ignore-sync bit with obey-sync as the default.
module ocd_top
   import ocd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic sync_n,
   output logic [2:0] channel2_first_output_pair_p,
   output logic [2:0] channel2_first_output_pair_n,
   output logic [2:0] channel2_first_output_pair_oe_n,
   output logic [2:0] channel3_first_output_pair_p,
   output logic [2:0] channel3_first_output_pair_n,
   output logic [2:0] channel3_first_output_pair_oe_n,
   output logic [1:0] duty_cycle_correction
);

   ////////////////////////////////////////////////////////////////////////
   // reset release
   logic rst_meta;
   logic rst_i;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_i <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_i <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sync pin: three flops, change taken once second and third agree
   logic sync_s1;
   logic sync_s2;
   logic sync_s3;
   logic sync_hold;
   logic next_sync_hold;

   always_comb begin
      next_sync_hold = sync_hold;
      if (sync_s2 == sync_s3) begin
         next_sync_hold = !sync_s3;
      end
   end

   always_ff @(posedge clk or negedge rst_i) begin
      if (!rst_i) begin
         sync_s1 <= 1'b1;
         sync_s2 <= 1'b1;
         sync_s3 <= 1'b1;
         sync_hold <= 1'b0;
      end else begin
         sync_s1 <= sync_n;
         sync_s2 <= sync_s1;
         sync_s3 <= sync_s2;
         sync_hold <= next_sync_hold;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register file
   logic [7:0] div2_cycle_counts;
   logic [7:0] divider2_force_start_phase;
   logic [7:0] channel2_power_and_correction;
   logic [7:0] divider3_cycle_counts;
   logic [7:0] divider3_control;
   logic [7:0] channel3_power_and_correction;
   logic [7:0] next_div2_cycle_counts;
   logic [7:0] next_divider2_force_start_phase;
   logic [7:0] next_channel2_power_and_correction;
   logic [7:0] next_divider3_cycle_counts;
   logic [7:0] next_divider3_control;
   logic [7:0] next_channel3_power_and_correction;
   logic [31:0] next_dat;
   logic next_ack;
   logic [9:0] idx;
   logic wr_take;
   logic [1:0] div_level;

   function automatic logic ocd_hit(input logic [9:0] a, input logic [9:0] b);
      ocd_hit = (a == b);
   endfunction

   assign idx = wb_adr_i[11:2];
   assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

   always_comb begin
      next_div2_cycle_counts = div2_cycle_counts;
      next_divider2_force_start_phase = divider2_force_start_phase;
      next_channel2_power_and_correction = channel2_power_and_correction;
      next_divider3_cycle_counts = divider3_cycle_counts;
      next_divider3_control = divider3_control;
      next_channel3_power_and_correction = channel3_power_and_correction;
      if (wr_take) begin
         if (ocd_hit(idx, `OCD_IDX_DIV2_COUNTS)) begin
            next_div2_cycle_counts = wb_dat_i[7:0];
         end
         if (ocd_hit(idx, `OCD_IDX_DIV2_CTRL)) begin
            next_divider2_force_start_phase = wb_dat_i[7:0];
         end
         if (ocd_hit(idx, `OCD_IDX_CH2_PWR)) begin
            next_channel2_power_and_correction = wb_dat_i[7:0] & `OCD_PWR_MASK;
         end
         if (ocd_hit(idx, `OCD_IDX_DIV3_COUNTS)) begin
            next_divider3_cycle_counts = wb_dat_i[7:0];
         end
         if (ocd_hit(idx, `OCD_IDX_DIV3_CTRL)) begin
            next_divider3_control = wb_dat_i[7:0];
         end
         if (ocd_hit(idx, `OCD_IDX_CH3_PWR)) begin
            next_channel3_power_and_correction = wb_dat_i[7:0] & `OCD_PWR_MASK;
         end
      end
   end

   always_comb begin
      next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
      next_dat = 32'h0;
      if (ocd_hit(idx, `OCD_IDX_DIV2_COUNTS)) begin
         next_dat[7:0] = div2_cycle_counts;
      end else if (ocd_hit(idx, `OCD_IDX_DIV2_CTRL)) begin
         next_dat[7:0] = divider2_force_start_phase;
      end else if (ocd_hit(idx, `OCD_IDX_CH2_PWR)) begin
         next_dat[7:0] = channel2_power_and_correction;
      end else if (ocd_hit(idx, `OCD_IDX_DIV3_COUNTS)) begin
         next_dat[7:0] = divider3_cycle_counts;
      end else if (ocd_hit(idx, `OCD_IDX_DIV3_CTRL)) begin
         next_dat[7:0] = divider3_control;
      end else if (ocd_hit(idx, `OCD_IDX_CH3_PWR)) begin
         next_dat[7:0] = channel3_power_and_correction;
      end else if (ocd_hit(idx, `OCD_IDX_STATUS)) begin
         next_dat[2:0] = {sync_hold, div_level};
      end
      if (!next_ack) begin
         next_dat = wb_dat_o;
      end
   end

   always_ff @(posedge clk or negedge rst_i) begin
      if (!rst_i) begin
         div2_cycle_counts <= `OCD_RST_DIV2_COUNTS;
         divider2_force_start_phase <= `OCD_RST_DIV2_CTRL;
         channel2_power_and_correction <= `OCD_RST_CH2_PWR;
         divider3_cycle_counts <= `OCD_RST_DIV3_COUNTS;
         divider3_control <= `OCD_RST_DIV3_CTRL;
         channel3_power_and_correction <= `OCD_RST_CH3_PWR;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         div2_cycle_counts <= next_div2_cycle_counts;
         divider2_force_start_phase <= next_divider2_force_start_phase;
         channel2_power_and_correction <= next_channel2_power_and_correction;
         divider3_cycle_counts <= next_divider3_cycle_counts;
         divider3_control <= next_divider3_control;
         channel3_power_and_correction <= next_channel3_power_and_correction;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // dividers
   logic div2_out;
   logic div3_out;

   ocd_divider u_div2 (
      .clk(clk),
      .rst_n(rst_i),
      .low_cnt(div2_cycle_counts[`OCD_LOW_MSB:`OCD_LOW_LSB]),
      .high_cnt(div2_cycle_counts[`OCD_HIGH_MSB:`OCD_HIGH_LSB]),
      .bypass(divider2_force_start_phase[`OCD_BYPASS_BIT]),
      .ignore_sync(divider2_force_start_phase[`OCD_IGNSYNC_BIT]),
      .force_high(divider2_force_start_phase[`OCD_FORCE_BIT]),
      .start_high(divider2_force_start_phase[`OCD_START_BIT]),
      .phase(divider2_force_start_phase[`OCD_PHASE_MSB:`OCD_PHASE_LSB]),
      .sync_hold(sync_hold),
      .level(div_level[0]),
      .div_out(div2_out)
   );

   ocd_divider u_div3 (
      .clk(clk),
      .rst_n(rst_i),
      .low_cnt(divider3_cycle_counts[`OCD_LOW_MSB:`OCD_LOW_LSB]),
      .high_cnt(divider3_cycle_counts[`OCD_HIGH_MSB:`OCD_HIGH_LSB]),
      .bypass(divider3_control[`OCD_BYPASS_BIT]),
      .ignore_sync(divider3_control[`OCD_IGNSYNC_BIT]),
      .force_high(divider3_control[`OCD_FORCE_BIT]),
      .start_high(divider3_control[`OCD_START_BIT]),
      .phase(divider3_control[`OCD_PHASE_MSB:`OCD_PHASE_LSB]),
      .sync_hold(sync_hold),
      .level(div_level[1]),
      .div_out(div3_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // output pairs and correction enables
   logic pd2;
   logic pd3;

   assign pd2 = channel2_power_and_correction[`OCD_PD_BIT];
   assign pd3 = channel3_power_and_correction[`OCD_PD_BIT];

   assign channel2_first_output_pair_p = {3{div2_out && !pd2}};
   assign channel2_first_output_pair_n = {3{!div2_out && !pd2}};
   assign channel2_first_output_pair_oe_n = {3{pd2}};

   assign channel3_first_output_pair_p = {3{div3_out && !pd3}};
   assign channel3_first_output_pair_n = {3{!div3_out && !pd3}};
   assign channel3_first_output_pair_oe_n = {3{pd3}};

   assign duty_cycle_correction[0] = !channel2_power_and_correction[`OCD_DCCDIS_BIT];
   assign duty_cycle_correction[1] = !channel3_power_and_correction[`OCD_DCCDIS_BIT];

   ////////////////////////////////////////////////////////////////////////
   a_pd_ch2: assert property (@(posedge clk) disable iff (!rst_i)
      (wr_take && ocd_hit(idx, `OCD_IDX_CH2_PWR) && wb_dat_i[`OCD_PD_BIT])
      |=> (channel2_first_output_pair_oe_n == 3'h7 && channel2_first_output_pair_p == 3'h0))
      else $error("channel two pairs not floated");

   a_pd_ch3: assert property (@(posedge clk) disable iff (!rst_i)
      (wr_take && ocd_hit(idx, `OCD_IDX_CH3_PWR) && !wb_dat_i[`OCD_PD_BIT])
      |=> (channel3_first_output_pair_oe_n == 3'h0))
      else $error("channel three pairs not driven");

   a_dcc_write: assert property (@(posedge clk) disable iff (!rst_i)
      (wr_take && ocd_hit(idx, `OCD_IDX_CH2_PWR))
      |=> (duty_cycle_correction[0] == !$past(wb_dat_i[`OCD_DCCDIS_BIT])))
      else $error("correction enable does not follow write");

   a_ignore_div2: assert property (@(posedge clk) disable iff (!rst_i)
      (wr_take && ocd_hit(idx, `OCD_IDX_DIV2_CTRL))
      |=> (divider2_force_start_phase[`OCD_IGNSYNC_BIT] == $past(wb_dat_i[`OCD_IGNSYNC_BIT])))
      else $error("divider two ignore-sync not stored");

   a_wb_answer: assert property (@(posedge clk) disable iff (!rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer not one cycle later");

   a_pd_ch3_float: assert property (@(posedge clk) disable iff (!rst_i)
      (wr_take && ocd_hit(idx, `OCD_IDX_CH3_PWR) && wb_dat_i[`OCD_PD_BIT])
      |=> (channel3_first_output_pair_oe_n == 3'h7 && channel3_first_output_pair_n == 3'h0))
      else $error("channel three pairs not floated");

   a_dcc_ch3: assert property (@(posedge clk) disable iff (!rst_i)
      (wr_take && ocd_hit(idx, `OCD_IDX_CH3_PWR))
      |=> (duty_cycle_correction[1] == !$past(wb_dat_i[`OCD_DCCDIS_BIT])))
      else $error("channel three correction enable does not follow write");

   a_div3_ctrl: assert property (@(posedge clk) disable iff (!rst_i)
      (wr_take && ocd_hit(idx, `OCD_IDX_DIV3_CTRL))
      |=> (divider3_control == $past(wb_dat_i[7:0])))
      else $error("divider three control not stored");

   a_sync_filter: assert property (@(posedge clk) disable iff (!rst_i)
      (sync_s2 == sync_s3) |=> (sync_hold == !$past(sync_s3)))
      else $error("sync pin filter wrong");

   a_sel_masked: assert property (@(posedge clk) disable iff (!rst_i)
      (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && !wb_sel_i[0])
      |=> $stable(divider3_cycle_counts))
      else $error("write without low byte lane landed");

   a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_i)
      (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && idx > `OCD_IDX_STATUS)
      |=> (wb_dat_o == 32'h0))
      else $error("unmapped read not zero");

endmodule
